// [rtl/mtr_cfg.svh]
`ifndef MTR_CFG_SVH
`define MTR_CFG_SVH

// register byte offsets
`define MTR_OFS_CTRL 8'h00
`define MTR_OFS_GO 8'h04
`define MTR_OFS_RT_EN 8'h08
`define MTR_OFS_STK_PTR 8'h0C
`define MTR_OFS_STK_LEN 8'h10
`define MTR_OFS_FRAMES 8'h14
`define MTR_OFS_STATUS 8'h18
`define MTR_OFS_IRQ_STAT 8'h1C
`define MTR_OFS_IRQ_MASK 8'h20
`define MTR_OFS_TIME 8'h24
`define MTR_OFS_PP_STAT 8'h28

// operating code and enable vector fields
`define MTR_OP_RESP_BIT 1
`define MTR_OP_ME_BIT 5
`define MTR_OP_NOWC_BIT 7
`define MTR_EN_CNT_BIT 31
// status and command word fields
`define MTR_ME_BIT 10
`define MTR_TR_BIT 10
// irq status bits
`define MTR_IRQ_MATCH 0
`define MTR_IRQ_PASSIVE 1
`define MTR_IRQ_OFFLINE 2
`define MTR_IRQ_W 3

// stack entry word offsets and default data base
`define MTR_ENT_STAT 16'h0001
`define MTR_ENT_PTR 16'h0002
`define MTR_ENT_TAG 16'h0003
`define MTR_DFLT_BASE 16'h0000

// reset values
`define MTR_RST_CTRL 16'h0000
`define MTR_RST_RT_EN 32'h0000_0000
`define MTR_RST_STK 16'h0000
`define MTR_RST_FRAMES 16'h0001
`define MTR_RST_PP_STAT 26'h000_0000

// timing
`define MTR_CLK_PERIOD_NS 50
`define MTR_RESP_TIME_NS 8000
`define MTR_RESP_CYCLES ((`MTR_RESP_TIME_NS + `MTR_CLK_PERIOD_NS - 1) / `MTR_CLK_PERIOD_NS)
`define MTR_PP_TIME_NS 2000
`define MTR_PP_CYCLES (`MTR_PP_TIME_NS / `MTR_CLK_PERIOD_NS)
`define MTR_QUIET_TIME_NS 1000000
`define MTR_QUIET_CYCLES (`MTR_QUIET_TIME_NS / `MTR_CLK_PERIOD_NS)
`define MTR_US_CYCLES (1000 / `MTR_CLK_PERIOD_NS)

`endif

// [rtl/mtr_pkg.sv]
package mtr_pkg;
  // responder engine states
  typedef enum logic [3:0] {
    MTR_LISTEN,
    MTR_SCAN_CHK,
    MTR_GET_STAT,
    MTR_GET_PTR,
    MTR_ROUTE,
    MTR_RX_DATA,
    MTR_WAIT,
    MTR_SEND_STAT,
    MTR_DATA_RD,
    MTR_DATA_TX
  } mtr_state_type;
endpackage

// [rtl/mtr_quiet.sv]
`timescale 1ns/10ps
// bus activity synchroniser and long-silence detector
module mtr_quiet #(
  parameter int QUIET_CYCLES = 20000
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // raw activity pins, bus a in bit 0
  input wire logic [1:0] act_i,
  // results
  output logic active_o,
  output logic passive_o
);
  logic [1:0] meta_reg; // first stage, read only by sync_reg
  logic [1:0] sync_reg; // second stage
  logic [31:0] cnt_reg; // silent cycles seen
  logic fired_reg; // passive already flagged this gap

  // two-stage synchroniser on both buses
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
    end else begin
      meta_reg <= act_i;
      sync_reg <= meta_reg;
    end
  end

  // silence counter; only one passive pulse per gap
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
      fired_reg <= 1'b0;
      active_o <= 1'b0;
      passive_o <= 1'b0;
    end else begin
      active_o <= |sync_reg;
      passive_o <= 1'b0;
      if (|sync_reg) begin
        cnt_reg <= '0;
        fired_reg <= 1'b0;
      end else if (!fired_reg) begin
        cnt_reg <= cnt_reg + 32'd1;
        if (cnt_reg == 32'(QUIET_CYCLES - 1)) begin
          passive_o <= 1'b1;
          fired_reg <= 1'b1;
        end
      end
    end
  end
endmodule

// [rtl/mtr_timer.sv]
`timescale 1ns/10ps
// one-shot delay: done pulses count edges after the start edge
module mtr_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // control
  input wire logic start_i,
  input wire logic [W-1:0] count_i,
  // result
  output logic done_o
);
  logic [W-1:0] cnt_reg; // cycles still to go
  logic run_reg; // counting

  // countdown; a new start restarts it
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_o <= 1'b0;
    end else if (start_i) begin
      cnt_reg <= count_i;
      run_reg <= 1'b1;
      done_o <= 1'b0;
    end else begin
      done_o <= run_reg && (cnt_reg == W'(1));
      if (run_reg) begin
        cnt_reg <= cnt_reg - W'(1);
        if (cnt_reg == W'(1)) begin
          run_reg <= 1'b0;
        end
      end
    end
  end
endmodule

// [rtl/mtr_top.sv]
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "mtr_cfg.svh"
module mtr_top
  import mtr_pkg::*;
#(
  parameter int QUIET_CYCLES = `MTR_QUIET_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // raw bus activity pins
  input wire logic bus_a_act_i,
  input wire logic bus_b_act_i,
  // decoded 1553 words
  input wire logic rx_valid_i,
  input wire logic [15:0] rx_word_i,
  input wire logic rx_cmd_i,
  input wire logic rx_bus_b_i,
  // decoded pp words
  input wire logic pp_valid_i,
  input wire logic [25:0] pp_word_i,
  input wire logic pp_gng_i,
  // 1553 transmitter
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [15:0] tx_word_o,
  output logic tx_status_o,
  output logic tx_bus_b_o,
  // pp transmitter
  output logic pp_tx_valid_o,
  output logic [25:0] pp_tx_word_o,
  // shared memory, asynchronous read
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i,
  // interrupt
  output logic irq_o
);
  // software registers
  logic [15:0] ctrl_reg; // operating code
  logic [31:0] rt_en_reg; // terminal enables, bit 31 data source
  logic [15:0] stk_ptr_reg;
  logic [15:0] stk_len_reg;
  logic [15:0] frames_reg; // frames per go, 0 runs forever
  logic [`MTR_IRQ_W-1:0] irq_stat_reg;
  logic [`MTR_IRQ_W-1:0] irq_mask_reg;
  logic [25:0] pp_stat_reg; // pp status word
  // ahb data phase
  logic ph_reg;
  logic ph_wr_reg;
  logic [7:0] ph_addr_reg;
  logic go_wr; // go written this cycle
  logic [31:0] rd_data;
  // frame control
  logic online_reg;
  logic fake_act_reg; // emulated activity after go
  logic [15:0] frames_left_reg;
  logic bus_act;
  logic passive;
  // time base
  logic [15:0] time_reg; // microseconds
  logic [7:0] pre_reg;
  // engine
  mtr_state_type state_reg;
  logic [15:0] idx_reg; // stack entry scanned
  logic [15:0] cmd_reg;
  logic [15:0] tag_reg; // detection time
  logic [15:0] stat_reg; // status to send
  logic [15:0] dptr_reg; // data block base
  logic matched_reg;
  logic me_reg; // error reply, no data
  logic [5:0] wc_reg; // data words in message
  logic [5:0] k_reg; // data words done
  logic [15:0] inc_reg; // hardware data counter
  logic resp_start_reg;
  logic resp_done;
  logic ev_match_reg;
  // pp
  logic pp_start_reg;
  logic pp_done;
  logic [25:0] pp_hold_reg;

  wire resp_mode = ctrl_reg[`MTR_OP_RESP_BIT];
  wire accept = hsel_i && htrans_i[1] && hready_i;

  // terminal simulated? broadcast never is
  function automatic logic rt_on(input logic [4:0] a, input logic [31:0] en);
    rt_on = (a != 5'h1F) && en[a];
  endfunction

  // stack entry compares with command
  function automatic logic cmd_match(input logic [15:0] e, input logic [15:0] c, input logic nowc);
    cmd_match = (e[15:5] == c[15:5]) && (nowc || (e[4:0] == c[4:0]));
  endfunction

  // ahb handshake, one wait state each transfer
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ph_reg <= 1'b0;
      ph_wr_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
      hreadyout_o <= 1'b1;
      hrdata_o <= 32'h0000_0000;
      hresp_o <= 1'b0;
    end else if (ph_reg) begin
      ph_reg <= 1'b0;
      hreadyout_o <= 1'b1;
      hrdata_o <= ph_wr_reg ? 32'h0000_0000 : rd_data;
    end else if (accept) begin
      ph_reg <= 1'b1;
      ph_wr_reg <= hwrite_i;
      ph_addr_reg <= haddr_i[7:0];
      hreadyout_o <= 1'b0;
    end
  end

  assign go_wr = ph_reg && ph_wr_reg && (ph_addr_reg == `MTR_OFS_GO) && hwdata_i[0];

  // register writes; data arrives in the data phase
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_reg <= `MTR_RST_CTRL;
      rt_en_reg <= `MTR_RST_RT_EN;
      stk_ptr_reg <= `MTR_RST_STK;
      stk_len_reg <= `MTR_RST_STK;
      frames_reg <= `MTR_RST_FRAMES;
      irq_mask_reg <= '0;
      pp_stat_reg <= `MTR_RST_PP_STAT;
    end else if (ph_reg && ph_wr_reg) begin
      if (ph_addr_reg == `MTR_OFS_CTRL) begin
        ctrl_reg <= hwdata_i[15:0];
      end else if (ph_addr_reg == `MTR_OFS_RT_EN) begin
        rt_en_reg <= hwdata_i;
      end else if (ph_addr_reg == `MTR_OFS_STK_PTR) begin
        stk_ptr_reg <= hwdata_i[15:0];
      end else if (ph_addr_reg == `MTR_OFS_STK_LEN) begin
        stk_len_reg <= hwdata_i[15:0];
      end else if (ph_addr_reg == `MTR_OFS_FRAMES) begin
        frames_reg <= hwdata_i[15:0];
      end else if (ph_addr_reg == `MTR_OFS_IRQ_MASK) begin
        irq_mask_reg <= hwdata_i[`MTR_IRQ_W-1:0];
      end else if (ph_addr_reg == `MTR_OFS_PP_STAT) begin
        pp_stat_reg <= hwdata_i[25:0];
      end
    end
  end

  // read decode; unmapped reads zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (ph_addr_reg == `MTR_OFS_CTRL) begin
      rd_data = {16'h0000, ctrl_reg};
    end else if (ph_addr_reg == `MTR_OFS_RT_EN) begin
      rd_data = rt_en_reg;
    end else if (ph_addr_reg == `MTR_OFS_STK_PTR) begin
      rd_data = {16'h0000, stk_ptr_reg};
    end else if (ph_addr_reg == `MTR_OFS_STK_LEN) begin
      rd_data = {16'h0000, stk_len_reg};
    end else if (ph_addr_reg == `MTR_OFS_FRAMES) begin
      rd_data = {16'h0000, frames_reg};
    end else if (ph_addr_reg == `MTR_OFS_STATUS) begin
      rd_data = {frames_left_reg, 13'h0000, state_reg != MTR_LISTEN, online_reg, fake_act_reg | bus_act};
    end else if (ph_addr_reg == `MTR_OFS_IRQ_STAT) begin
      rd_data = {29'h0000_0000, irq_stat_reg};
    end else if (ph_addr_reg == `MTR_OFS_IRQ_MASK) begin
      rd_data = {29'h0000_0000, irq_mask_reg};
    end else if (ph_addr_reg == `MTR_OFS_TIME) begin
      rd_data = {16'h0000, time_reg};
    end else if (ph_addr_reg == `MTR_OFS_PP_STAT) begin
      rd_data = {6'h00, pp_stat_reg};
    end
  end

  // silence detector
  mtr_quiet #(.QUIET_CYCLES(QUIET_CYCLES)) u_quiet (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .act_i({bus_b_act_i, bus_a_act_i}),
    .active_o(bus_act),
    .passive_o(passive)
  );

  // go arms, passive counts frames down
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      online_reg <= 1'b0;
      fake_act_reg <= 1'b0;
      frames_left_reg <= 16'h0000;
    end else if (!resp_mode) begin
      online_reg <= 1'b0;
      fake_act_reg <= 1'b0;
    end else if (go_wr) begin
      online_reg <= 1'b1;
      fake_act_reg <= 1'b1;
      frames_left_reg <= frames_reg;
    end else begin
      if (bus_act) begin
        fake_act_reg <= 1'b0;
      end
      if (passive && online_reg && (frames_left_reg != 16'h0000)) begin
        frames_left_reg <= frames_left_reg - 16'h0001;
        if (frames_left_reg == 16'h0001) begin
          online_reg <= 1'b0;
        end
      end
    end
  end

  // microsecond time base for tags
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pre_reg <= 8'h00;
      time_reg <= 16'h0000;
    end else if (pre_reg == 8'(`MTR_US_CYCLES - 1)) begin
      pre_reg <= 8'h00;
      time_reg <= time_reg + 16'h0001;
    end else begin
      pre_reg <= pre_reg + 8'h01;
    end
  end

  // response delay from end of command or last data
  mtr_timer #(.W(16)) u_resp (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .start_i(resp_start_reg),
    .count_i(16'(`MTR_RESP_CYCLES)),
    .done_o(resp_done)
  );

  // responder engine
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_reg <= MTR_LISTEN;
      idx_reg <= 16'h0000;
      cmd_reg <= 16'h0000;
      tag_reg <= 16'h0000;
      stat_reg <= 16'h0000;
      dptr_reg <= 16'h0000;
      matched_reg <= 1'b0;
      me_reg <= 1'b0;
      wc_reg <= 6'h00;
      k_reg <= 6'h00;
      inc_reg <= 16'h0000;
      resp_start_reg <= 1'b0;
      ev_match_reg <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_word_o <= 16'h0000;
      tx_status_o <= 1'b0;
      tx_bus_b_o <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 16'h0000;
    end else begin
      resp_start_reg <= 1'b0;
      ev_match_reg <= 1'b0;
      case (state_reg)
        MTR_LISTEN: begin
          mem_rd_o <= 1'b0;
          mem_wr_o <= 1'b0;
          if (rx_valid_i && rx_cmd_i && online_reg && rt_on(rx_word_i[15:11], rt_en_reg)) begin
            cmd_reg <= rx_word_i;
            tx_bus_b_o <= rx_bus_b_i;
            tag_reg <= time_reg;
            wc_reg <= (rx_word_i[4:0] == 5'h00) ? 6'd32 : {1'b0, rx_word_i[4:0]};
            idx_reg <= 16'h0000;
            mem_addr_o <= stk_ptr_reg;
            mem_rd_o <= 1'b1;
            matched_reg <= 1'b0;
            me_reg <= 1'b0;
            stat_reg <= {rx_word_i[15:11], 11'h000};
            dptr_reg <= `MTR_DFLT_BASE;
            state_reg <= (stk_len_reg == 16'h0000) ? MTR_ROUTE : MTR_SCAN_CHK;
          end
        end
        MTR_SCAN_CHK: begin
          if (cmd_match(mem_rdata_i, cmd_reg, ctrl_reg[`MTR_OP_NOWC_BIT])) begin
            mem_addr_o <= mem_addr_o + `MTR_ENT_STAT;
            ev_match_reg <= 1'b1;
            state_reg <= MTR_GET_STAT;
          end else if (idx_reg + 16'h0001 == stk_len_reg) begin
            mem_rd_o <= 1'b0;
            state_reg <= MTR_ROUTE;
          end else begin
            idx_reg <= idx_reg + 16'h0001;
            mem_addr_o <= mem_addr_o + 16'h0004;
          end
        end
        MTR_GET_STAT: begin
          stat_reg <= mem_rdata_i;
          mem_addr_o <= mem_addr_o + 16'h0001;
          state_reg <= MTR_GET_PTR;
        end
        MTR_GET_PTR: begin
          dptr_reg <= mem_rdata_i;
          matched_reg <= 1'b1;
          mem_rd_o <= 1'b0;
          mem_wr_o <= 1'b1;
          mem_addr_o <= mem_addr_o + 16'h0001;
          mem_wdata_o <= tag_reg;
          state_reg <= MTR_ROUTE;
        end
        MTR_ROUTE: begin
          mem_wr_o <= 1'b0;
          k_reg <= 6'h00;
          if (!matched_reg && ctrl_reg[`MTR_OP_ME_BIT]) begin
            me_reg <= 1'b1;
            stat_reg[`MTR_ME_BIT] <= 1'b1;
          end
          if (cmd_reg[`MTR_TR_BIT]) begin
            resp_start_reg <= 1'b1;
            state_reg <= MTR_WAIT;
          end else begin
            state_reg <= MTR_RX_DATA;
          end
        end
        MTR_RX_DATA: begin
          mem_wr_o <= 1'b0;
          if (rx_valid_i && rx_cmd_i) begin
            // new command cuts the message short
            state_reg <= MTR_LISTEN;
          end else if (rx_valid_i) begin
            mem_wr_o <= matched_reg;
            mem_addr_o <= dptr_reg + {10'h000, k_reg};
            mem_wdata_o <= rx_word_i;
            k_reg <= k_reg + 6'h01;
            if (k_reg + 6'h01 == wc_reg) begin
              resp_start_reg <= 1'b1;
              state_reg <= MTR_WAIT;
            end
          end
        end
        MTR_WAIT: begin
          mem_wr_o <= 1'b0;
          if (resp_done) begin
            tx_valid_o <= 1'b1;
            tx_word_o <= stat_reg;
            tx_status_o <= 1'b1;
            state_reg <= MTR_SEND_STAT;
          end
        end
        MTR_SEND_STAT: begin
          if (tx_ready_i) begin
            tx_valid_o <= 1'b0;
            k_reg <= 6'h00;
            if (cmd_reg[`MTR_TR_BIT] && !me_reg) begin
              mem_addr_o <= dptr_reg;
              mem_rd_o <= 1'b1;
              state_reg <= MTR_DATA_RD;
            end else begin
              state_reg <= MTR_LISTEN;
            end
          end
        end
        MTR_DATA_RD: begin
          tx_valid_o <= 1'b1;
          tx_status_o <= 1'b0;
          if (rt_en_reg[`MTR_EN_CNT_BIT]) begin
            tx_word_o <= inc_reg;
            inc_reg <= inc_reg + 16'h0001;
          end else begin
            tx_word_o <= mem_rdata_i;
          end
          state_reg <= MTR_DATA_TX;
        end
        MTR_DATA_TX: begin
          if (tx_ready_i) begin
            tx_valid_o <= 1'b0;
            k_reg <= k_reg + 6'h01;
            if (k_reg + 6'h01 == wc_reg) begin
              mem_rd_o <= 1'b0;
              state_reg <= MTR_LISTEN;
            end else begin
              mem_addr_o <= mem_addr_o + 16'h0001;
              state_reg <= MTR_DATA_RD;
            end
          end
        end
        default: begin
          state_reg <= MTR_LISTEN;
        end
      endcase
    end
  end

  // pp reply delay
  mtr_timer #(.W(16)) u_pp (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .start_i(pp_start_reg),
    .count_i(16'(`MTR_PP_CYCLES - 2)),
    .done_o(pp_done)
  );

  // pp remote unit: echo data, answer go/no-go
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pp_start_reg <= 1'b0;
      pp_hold_reg <= 26'h000_0000;
      pp_tx_valid_o <= 1'b0;
      pp_tx_word_o <= 26'h000_0000;
    end else begin
      pp_start_reg <= 1'b0;
      pp_tx_valid_o <= pp_done;
      if (pp_done) begin
        pp_tx_word_o <= pp_hold_reg;
      end
      if (pp_valid_i && online_reg && rt_on({1'b0, pp_word_i[25:22]}, rt_en_reg)) begin
        pp_start_reg <= 1'b1;
        pp_hold_reg <= pp_gng_i ? pp_stat_reg : pp_word_i;
      end
    end
  end

  // sticky events, write one clears, set wins
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_stat_reg <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((ph_reg && ph_wr_reg && (ph_addr_reg == `MTR_OFS_IRQ_STAT))
                      ? hwdata_i[`MTR_IRQ_W-1:0] : 3'h0))
                      | {passive && online_reg && (frames_left_reg == 16'h0001), passive, ev_match_reg};
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule

// [testbench/mtr_bc_model.sv]
`timescale 1ns/10ps
// far-side controller: sends words, takes replies
module mtr_bc_model (
  // clock
  input wire logic mclk_i,
  // reply path
  input wire logic tx_valid_i,
  input wire logic tx_bus_b_i,
  output logic tx_ready_o,
  // activity and decoded words
  output logic act_a_o,
  output logic act_b_o,
  output logic rx_valid_o,
  output logic [15:0] rx_word_o,
  output logic rx_cmd_o,
  output logic rx_bus_b_o,
  output logic pp_valid_o,
  output logic [25:0] pp_word_o,
  output logic pp_gng_o
);
  logic [1:0] talk = 2'h0; // own word on bus a or b
  logic slow = 1'h0; // slow encoder takes every other cycle
  initial begin
    {rx_valid_o, rx_word_o, rx_cmd_o, rx_bus_b_o} = 19'h0;
    {pp_valid_o, pp_word_o, pp_gng_o, tx_ready_o} = 29'h0;
  end
  // lines are busy for our words and for replies in flight
  assign act_a_o = talk[0] | (tx_valid_i & !tx_bus_b_i);
  assign act_b_o = talk[1] | (tx_valid_i & tx_bus_b_i);
  // encoder readiness
  always @(posedge mclk_i) tx_ready_o <= slow ? ~tx_ready_o : 1'h1;
  // one word: 20 busy cycles, then the decode pulse
  task automatic send(input logic p, input logic [25:0] w, input logic g, input logic b);
    @(posedge mclk_i);
    talk[b] <= 1'h1;
    repeat (20) @(posedge mclk_i);
    {rx_word_o, rx_cmd_o, rx_bus_b_o, rx_valid_o} <= {w[15:0], !p, b, !p};
    {pp_word_o, pp_gng_o, pp_valid_o} <= {w, g, p};
    @(posedge mclk_i);
    // released lines show no stale word
    {rx_word_o, rx_valid_o, rx_cmd_o} <= {~w[15:0], 2'h0};
    {pp_word_o, pp_valid_o, talk} <= {~w, 3'h0};
  endtask
endmodule

// [testbench/mtr_top_assertions.sv]
`timescale 1ns/10ps
// watches the responder top ports
module mtr_top_assertions (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // register bus
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // command and reply words
  input wire logic rx_valid_i,
  input wire logic rx_cmd_i,
  input wire logic rx_bus_b_i,
  input wire logic tx_ready_i,
  input wire logic tx_valid_o,
  input wire logic [15:0] tx_word_o,
  input wire logic tx_status_o,
  input wire logic tx_bus_b_o,
  // pp words
  input wire logic pp_valid_i,
  input wire logic [25:0] pp_word_i,
  input wire logic pp_gng_i,
  input wire logic pp_tx_valid_o,
  input wire logic [25:0] pp_tx_word_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic [15:0] since_reg; // cycles since last rx word
  logic bus_reg; // bus of the last command
  // saturating gap counter, so long idles never wrap
  always_ff @(posedge mclk_i) begin
    if (reset_i || rx_valid_i) since_reg <= 16'h0000;
    else if (since_reg != 16'hFFFF) since_reg <= since_reg + 16'h0001;
  end
  // bus of the last command
  always_ff @(posedge mclk_i) begin
    if (reset_i) bus_reg <= 1'h0;
    else if (rx_valid_i && rx_cmd_i) bus_reg <= rx_bus_b_i;
  end
  property p_rst_quiet;
    disable iff (1'h0) reset_i |=> hreadyout_o && !tx_valid_o && !pp_tx_valid_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy in reset");
  property p_ahb_wait;
    hsel_i && htrans_i[1] && hready_i |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_ahb_wait: assert property (p_ahb_wait) else $error("ahb wait state wrong");
  property p_okay;
    !hresp_o;
  endproperty
  a_okay: assert property (p_okay) else $error("ahb response not okay");
  property p_tx_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_word_o) && $stable(tx_status_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply word dropped");
  property p_tx_gap;
    $rose(tx_valid_o) && tx_status_o |-> since_reg >= 16'h00A0;
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("status sent too early");
  property p_tx_bus;
    tx_valid_o |-> tx_bus_b_o == bus_reg;
  endproperty
  a_tx_bus: assert property (p_tx_bus) else $error("reply on wrong bus");
  property p_pp_time;
    pp_tx_valid_o |-> $past(pp_valid_i, 41);
  endproperty
  a_pp_time: assert property (p_pp_time) else $error("pp reply not 2 us late");
  property p_pp_echo;
    pp_tx_valid_o && $past(pp_valid_i, 41) && !$past(pp_gng_i, 41) |-> pp_tx_word_o == $past(pp_word_i, 41);
  endproperty
  a_pp_echo: assert property (p_pp_echo) else $error("pp echo differs");
  property p_pp_pulse;
    pp_tx_valid_o |=> !pp_tx_valid_o;
  endproperty
  a_pp_pulse: assert property (p_pp_pulse) else $error("pp reply not a pulse");
endmodule

// [testbench/mtr_top_bench.sv]
`timescale 1ns/10ps
// self-checking bench for the responder
module mtr_top_bench;
  localparam int QC = 400; // silence window, kept above the reply gap
  logic mclk_i, reset_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, irq_o, mem_wr_o;
  logic [1:0] htrans_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic bus_a_act_i, bus_b_act_i, rx_valid_i, rx_cmd_i, rx_bus_b_i, pp_valid_i, pp_gng_i;
  logic tx_ready_i, tx_valid_o, tx_status_o, tx_bus_b_o, pp_tx_valid_o;
  logic [15:0] rx_word_i, tx_word_o, mem_addr_o, mem_wdata_o, mem_rdata_i, lfsr;
  logic [25:0] pp_word_i, pp_tx_word_o, pw;
  logic [15:0] mem [0:255]; // shared memory
  logic [17:0] tx_q [$]; // expected {bus, status, word}
  logic [25:0] pp_q [$]; // expected pp replies
  int error_cnt = 0, checks_done = 0;
  mtr_top #(.QUIET_CYCLES(QC)) u_dut (.mclk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .bus_a_act_i, .bus_b_act_i, .rx_valid_i, .rx_word_i, .rx_cmd_i, .rx_bus_b_i, .pp_valid_i,
    .pp_word_i, .pp_gng_i, .tx_ready_i, .tx_valid_o, .tx_word_o, .tx_status_o, .tx_bus_b_o,
    .pp_tx_valid_o, .pp_tx_word_o, .mem_rd_o(), .mem_wr_o, .mem_addr_o, .mem_wdata_o,
    .mem_rdata_i, .irq_o);
  mtr_bc_model u_bc (.mclk_i, .tx_valid_i(tx_valid_o), .tx_bus_b_i(tx_bus_b_o), .tx_ready_o(tx_ready_i),
    .act_a_o(bus_a_act_i), .act_b_o(bus_b_act_i), .rx_valid_o(rx_valid_i), .rx_word_o(rx_word_i),
    .rx_cmd_o(rx_cmd_i), .rx_bus_b_o(rx_bus_b_i), .pp_valid_o(pp_valid_i), .pp_word_o(pp_word_i),
    .pp_gng_o(pp_gng_i));
  // asynchronous read memory
  assign mem_rdata_i = mem[mem_addr_o[7:0]];
  always @(posedge mclk_i) if (mem_wr_o) mem[mem_addr_o[7:0]] <= mem_wdata_o;
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // single ahb transfer, waits each phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {hsel_i, htrans_i, hwrite_i, haddr_i} <= {1'h1, 2'h2, w, 24'h0, a};
    do @(posedge mclk_i); while (!hreadyout_o);
    {hsel_i, htrans_i, hwdata_i} <= {3'h0, d};
    do @(posedge mclk_i); while (!hreadyout_o);
    rd = hrdata_o;
  endtask
  task automatic ex(input logic [17:0] e);
    tx_q.push_back(e);
  endtask
  // wait for replies, then watch for strays
  task automatic fin(input string n);
    int k = 0;
    while (tx_q.size() + pp_q.size() > 0 && k < 3000) begin
      @(posedge mclk_i);
      k++;
    end
    repeat (300) @(posedge mclk_i);
    chk("pending", 1'h0, tx_q.size() + pp_q.size());
    $display("test %s done", n);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // oldest note against each reply
  always @(posedge mclk_i) begin
    if (tx_valid_o && tx_ready_i) chk("tx", tx_q.size() ? tx_q.pop_front() : 18'h3FFFF, {tx_bus_b_o, tx_status_o, tx_word_o});
    if (pp_tx_valid_o) chk("pp", pp_q.size() ? pp_q.pop_front() : 26'h3FFFFFF, pp_tx_word_o);
  end
  initial begin
    mclk_i = 1'h0;
    forever #25 mclk_i = ~mclk_i;
  end
  // watchdog, well above the expected run
  initial begin
    repeat (40000) @(posedge mclk_i);
    error_cnt++;
    test_done;
  end
  initial begin
    {reset_i, hsel_i, htrans_i, hwrite_i, haddr_i, hwdata_i} = {1'h1, 68'h0};
    lfsr = 16'h0026;
    for (int i = 0; i < 256; i++) begin
      lfsr = nxt(lfsr);
      mem[i] = lfsr;
    end
    // one stack entry: rt5 transmit, one word
    {mem[8'h40], mem[8'h41], mem[8'h42], mem[8'h43]} = 64'h2C21_2855_0060_0000;
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'h0;
    ahb(1'h0, 8'h14, 32'h0);
    chk("frames", 32'h1, rd);
    ahb(1'h0, 8'h80, 32'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'h1, 8'h00, 32'h2);
    ahb(1'h1, 8'h14, 32'h0);
    ahb(1'h1, 8'h08, 32'h60);
    ahb(1'h1, 8'h0C, 32'h40);
    ahb(1'h1, 8'h10, 32'h1);
    ahb(1'h1, 8'h28, 32'h02A5A5A5);
    u_bc.send(1'h0, 26'h2C21, 1'h0, 1'h1);
    fin("unarmed");
    ahb(1'h1, 8'h04, 32'h1);
    ahb(1'h0, 8'h18, 32'h0);
    chk("state", 2'h3, rd[1:0]);
    u_bc.slow = 1'h1;
    ex(18'h32855);
    ex({2'h2, mem[8'h60]});
    u_bc.send(1'h0, 26'h2C21, 1'h0, 1'h1);
    fin("match");
    chk("tag", 1'h1, mem[8'h43] != 16'h0000);
    u_bc.slow = 1'h0;
    ex(18'h13000);
    ex({2'h0, mem[8'h00]});
    u_bc.send(1'h0, 26'h3421, 1'h0, 1'h0);
    fin("default");
    ahb(1'h1, 8'h00, 32'h82);
    ex(18'h32855);
    ex({2'h2, mem[8'h60]});
    ex({2'h2, mem[8'h61]});
    u_bc.send(1'h0, 26'h2C22, 1'h0, 1'h1);
    fin("nowc");
    ahb(1'h1, 8'h00, 32'h22);
    ex(18'h13400);
    u_bc.send(1'h0, 26'h3421, 1'h0, 1'h0);
    fin("msgerr");
    u_bc.send(1'h0, 26'h3C21, 1'h0, 1'h0);
    fin("disabled");
    lfsr = nxt(lfsr);
    pw = {4'h5, 6'h0, lfsr};
    pp_q.push_back(pw);
    u_bc.send(1'h1, pw, 1'h0, 1'h0);
    fin("echo");
    pp_q.push_back(26'h2A5A5A5);
    u_bc.send(1'h1, {4'h5, 22'h1}, 1'h1, 1'h0);
    fin("gonogo");
    repeat (QC + 20) @(posedge mclk_i);
    chk("irq", 1'h0, irq_o);
    ahb(1'h1, 8'h20, 32'h2);
    repeat (2) @(posedge mclk_i);
    chk("irq", 1'h1, irq_o);
    ahb(1'h1, 8'h1C, 32'h2);
    repeat (2) @(posedge mclk_i);
    chk("irq", 1'h0, irq_o);
    ahb(1'h1, 8'h14, 32'h1);
    ahb(1'h1, 8'h04, 32'h1);
    ex(18'h32855);
    ex({2'h2, mem[8'h60]});
    u_bc.send(1'h0, 26'h2C21, 1'h0, 1'h1);
    fin("frame");
    repeat (QC + 20) @(posedge mclk_i);
    u_bc.send(1'h0, 26'h2C21, 1'h0, 1'h1);
    fin("offline");
    ahb(1'h0, 8'h18, 32'h0);
    chk("online", 1'h0, rd[1]);
    test_done;
  end
endmodule
bind mtr_top mtr_top_assertions u_chk (.*);
